// File: hw/gas_pkg.sv
package gas_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACK = 8'h04;
  localparam logic [7:0] ADDR_SAFETY = 8'h08;
  localparam logic [7:0] ADDR_HC_LIM = 8'h0C;
  localparam logic [7:0] ADDR_EF_LIM = 8'h10;
  localparam logic [7:0] ADDR_ATTEMPTS = 8'h14;
  localparam logic [7:0] ADDR_WARN = 8'h18;
  localparam logic [7:0] ADDR_SHUT = 8'h1C;
  localparam logic [7:0] ADDR_THR_BASE = 8'h40;
  localparam int THR_N = 20;

  // control register fields
  localparam int CTRL_LATCH_ALL = 0;
  localparam int CTRL_CAN_EN = 1;
  localparam int CTRL_OVERSHOOT_EN = 2;
  localparam int CTRL_ROT_DIR = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ************************************************************
  // threshold slots, index = (address - base) / 4
  // ************************************************************
  localparam int T_OIL_PRE = 0;
  localparam int T_OIL_TRIP = 1;
  localparam int T_TEMP_PRE = 2;
  localparam int T_TEMP_TRIP = 3;
  localparam int T_TEMP_LOW = 4;
  localparam int T_SPD_OV_PRE = 5;
  localparam int T_SPD_UN_PRE = 6;
  localparam int T_SPD_OV_TRIP = 7;
  localparam int T_SPD_UN_TRIP = 8;
  localparam int T_FRQ_OV_PRE = 9;
  localparam int T_FRQ_UN_PRE = 10;
  localparam int T_FRQ_OV_TRIP = 11;
  localparam int T_FRQ_UN_TRIP = 12;
  localparam int T_VLT_OV_PRE = 13;
  localparam int T_VLT_UN_PRE = 14;
  localparam int T_VLT_OV_TRIP = 15;
  localparam int T_VLT_UN_TRIP = 16;
  localparam int T_CUR_TRIP = 17;
  localparam int T_EARTH_TRIP = 18;
  localparam int T_OVERSHOOT = 19;
  // "over" limits reset to full scale, "under" limits and margin to zero
  localparam logic [THR_N-1:0][15:0] THR_RST = {
    16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF,
    16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000,
    16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};

  // ************************************************************
  // warning and shutdown bit positions
  // ************************************************************
  localparam int W_N = 11;
  localparam int W_OIL = 0, W_TEMP_HI = 1, W_TEMP_LO = 2, W_SPD_OV = 3;
  localparam int W_SPD_UN = 4, W_FRQ_OV = 5, W_FRQ_UN = 6, W_VLT_OV = 7;
  localparam int W_VLT_UN = 8, W_ECU = 9, W_CURRENT = 10;
  localparam int S_N = 13;
  localparam int S_EARTH = 0, S_FAIL_START = 1, S_ESTOP = 2, S_OIL = 3;
  localparam int S_TEMP_HI = 4, S_ROTATION = 5, S_SPD_OV = 6, S_SPD_UN = 7;
  localparam int S_FRQ_OV = 8, S_FRQ_UN = 9, S_VLT_OV = 10, S_VLT_UN = 11;
  localparam int S_CURRENT = 12;
  // shutdowns that are gated by the post-start delay and so may be reset
  localparam logic [12:0] S_DELAYED = 13'h0098;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] oil;
    logic [15:0] coolant;
    logic [15:0] speed;
    logic [15:0] freq;
    logic [15:0] volt;
    logic [15:0] current;
    logic [15:0] earth;
  } gas_meas_s;

  typedef struct packed {
    logic running;
    logic starting;
    logic fired;
    logic crank_end;
    logic rot_fwd;
    logic ecu_error;
  } gas_engine_s;

endpackage

// File: hw/gas_supervisor.sv
`timescale 1ns/10ps
`default_nettype none

module gas_supervisor #(
  parameter int TICK_CYCLES = gas_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [gas_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // measurements and engine status
  input wire gas_pkg::gas_meas_s meas,
  input wire gas_pkg::gas_engine_s engine,
  // operator and safety chain
  input wire logic estop_present,
  input wire logic stop_reset_btn,
  input wire logic fuel_req,
  input wire logic starter_req,
  // outputs
  output logic [gas_pkg::W_N-1:0] warn,
  output logic [gas_pkg::S_N-1:0] shutdown,
  output logic stop_engine,
  output logic fuel_en,
  output logic starter_en
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [gas_pkg::CTRL_W-1:0] ctrl_reg;
  logic ack_reg;
  logic [15:0] safety_ms_reg;
  logic [15:0] hc_lim_reg;
  logic [15:0] ef_lim_reg;
  logic [3:0] attempts_lim_reg;
  logic [gas_pkg::THR_N-1:0][15:0] thr_reg;
  logic [31:0] rdata_reg;
  logic [gas_pkg::W_N-1:0] warn_reg;
  logic [gas_pkg::S_N-1:0] shut_reg;
  logic [gas_pkg::W_N-1:0] warn_cond;
  logic [gas_pkg::S_N-1:0] shut_cond;
  logic reset_accept;
  logic blocking;
  logic [4:0] thr_idx;
  logic thr_hit;

  assign thr_idx = 5'((reg_addr - gas_pkg::ADDR_THR_BASE) >> 2);
  assign thr_hit = (reg_addr >= gas_pkg::ADDR_THR_BASE) && (reg_addr[1:0] == 2'h0) &&
                   (thr_idx < 5'(gas_pkg::THR_N));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_reg <= gas_pkg::CTRL_RST;
      safety_ms_reg <= 16'h0000;
      hc_lim_reg <= 16'h0000;
      ef_lim_reg <= 16'h0000;
      attempts_lim_reg <= 4'h0;
      thr_reg <= gas_pkg::THR_RST;
    end else if (reg_wr) begin
      if (reg_addr == gas_pkg::ADDR_CTRL) begin
        ctrl_reg <= reg_wdata[gas_pkg::CTRL_W-1:0];
      end
      if (reg_addr == gas_pkg::ADDR_SAFETY) begin
        safety_ms_reg <= reg_wdata[15:0];
      end
      if (reg_addr == gas_pkg::ADDR_HC_LIM) begin
        hc_lim_reg <= reg_wdata[15:0];
      end
      if (reg_addr == gas_pkg::ADDR_EF_LIM) begin
        ef_lim_reg <= reg_wdata[15:0];
      end
      if (reg_addr == gas_pkg::ADDR_ATTEMPTS) begin
        attempts_lim_reg <= reg_wdata[3:0];
      end
      if (thr_hit) begin
        thr_reg[thr_idx] <= reg_wdata[15:0];
      end
    end
  end

  // acknowledge is remembered until a stop/reset is accepted; a new ack wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else if (reg_wr && reg_addr == gas_pkg::ADDR_ACK) begin
      ack_reg <= 1'b1;
    end else if (reset_accept) begin
      ack_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= 32'h0000_0000;
      if (reg_addr == gas_pkg::ADDR_CTRL) rdata_reg <= 32'(ctrl_reg);
      if (reg_addr == gas_pkg::ADDR_ACK) rdata_reg <= 32'(ack_reg);
      if (reg_addr == gas_pkg::ADDR_SAFETY) rdata_reg <= 32'(safety_ms_reg);
      if (reg_addr == gas_pkg::ADDR_HC_LIM) rdata_reg <= 32'(hc_lim_reg);
      if (reg_addr == gas_pkg::ADDR_EF_LIM) rdata_reg <= 32'(ef_lim_reg);
      if (reg_addr == gas_pkg::ADDR_ATTEMPTS) rdata_reg <= 32'(attempts_lim_reg);
      if (reg_addr == gas_pkg::ADDR_WARN) rdata_reg <= 32'(warn_reg);
      if (reg_addr == gas_pkg::ADDR_SHUT) rdata_reg <= 32'(shut_reg);
      if (thr_hit) rdata_reg <= 32'(thr_reg[thr_idx]);
    end
  end
  assign reg_rdata = rdata_reg;

  // ************************************************************
  // millisecond tick and post-start delay
  // ************************************************************
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
  logic tick;
  logic [15:0] safety_cnt_reg;
  logic safety_on_reg;
  // own prescaler, restarted while stopped, so the first delay millisecond is a whole one
  logic [$clog2(TICK_CYCLES+1)-1:0] safety_pre_reg;

  assign tick = (tick_cnt_reg == '0);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= ($bits(tick_cnt_reg))'(TICK_CYCLES - 1);
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      safety_cnt_reg <= 16'h0000;
      safety_on_reg <= 1'b0;
      safety_pre_reg <= '0;
    end else if (!engine.running) begin
      safety_cnt_reg <= safety_ms_reg;
      safety_on_reg <= 1'b0;
      safety_pre_reg <= ($bits(safety_pre_reg))'(TICK_CYCLES - 1);
    end else begin
      if (safety_pre_reg == '0) begin
        safety_pre_reg <= ($bits(safety_pre_reg))'(TICK_CYCLES - 1);
        if (safety_cnt_reg != 16'h0000) begin
          safety_cnt_reg <= safety_cnt_reg - 16'h0001;
        end
      end else begin
        safety_pre_reg <= safety_pre_reg - 1'b1;
      end
      safety_on_reg <= (safety_cnt_reg == 16'h0000);
    end
  end

  // ************************************************************
  // time-over-trip accumulators (current and earth fault)
  // ************************************************************
  // a linear accumulator stands in for the inverse_time_curve: it counts
  // milliseconds over trip and restarts when the level drops back
  logic [1:0] over_trip;
  logic [1:0][15:0] over_lim;
  logic [1:0][15:0] acc_reg;
  logic [1:0] acc_done;

  assign over_trip[0] = meas.current > thr_reg[gas_pkg::T_CUR_TRIP];
  assign over_trip[1] = meas.earth > thr_reg[gas_pkg::T_EARTH_TRIP];
  assign over_lim[0] = hc_lim_reg;
  assign over_lim[1] = ef_lim_reg;

  for (genvar g = 0; g < 2; g++) begin : g_acc
    assign acc_done[g] = over_trip[g] && (acc_reg[g] >= over_lim[g]);
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        acc_reg[g] <= 16'h0000;
      end else if (!over_trip[g]) begin
        acc_reg[g] <= 16'h0000;
      end else if (tick && acc_reg[g] != 16'hFFFF) begin
        acc_reg[g] <= acc_reg[g] + 16'h0001;
      end
    end
  end

  // ************************************************************
  // start attempt counter
  // ************************************************************
  logic [3:0] attempts_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      attempts_reg <= 4'h0;
    end else if (engine.fired || reset_accept) begin
      attempts_reg <= 4'h0;
    end else if (engine.crank_end && attempts_reg != 4'hF) begin
      attempts_reg <= attempts_reg + 4'h1;
    end
  end

  // ************************************************************
  // alarm conditions
  // ************************************************************
  logic [15:0] spd_trip;
  logic [16:0] spd_trip_wide;

  assign spd_trip_wide = {1'b0, thr_reg[gas_pkg::T_SPD_OV_TRIP]} +
                         {1'b0, thr_reg[gas_pkg::T_OVERSHOOT]};
  assign spd_trip = (ctrl_reg[gas_pkg::CTRL_OVERSHOOT_EN] && engine.starting) ?
                    (spd_trip_wide[16] ? 16'hFFFF : spd_trip_wide[15:0]) :
                    thr_reg[gas_pkg::T_SPD_OV_TRIP];

  always_comb begin
    warn_cond = '0;
    warn_cond[gas_pkg::W_OIL] = safety_on_reg && (meas.oil < thr_reg[gas_pkg::T_OIL_PRE]);
    warn_cond[gas_pkg::W_TEMP_HI] = safety_on_reg &&
                                    (meas.coolant > thr_reg[gas_pkg::T_TEMP_PRE]);
    warn_cond[gas_pkg::W_TEMP_LO] = meas.coolant < thr_reg[gas_pkg::T_TEMP_LOW];
    warn_cond[gas_pkg::W_SPD_OV] = meas.speed > thr_reg[gas_pkg::T_SPD_OV_PRE];
    warn_cond[gas_pkg::W_SPD_UN] = meas.speed < thr_reg[gas_pkg::T_SPD_UN_PRE];
    warn_cond[gas_pkg::W_FRQ_OV] = meas.freq > thr_reg[gas_pkg::T_FRQ_OV_PRE];
    warn_cond[gas_pkg::W_FRQ_UN] = safety_on_reg && (meas.freq < thr_reg[gas_pkg::T_FRQ_UN_PRE]);
    warn_cond[gas_pkg::W_VLT_OV] = meas.volt > thr_reg[gas_pkg::T_VLT_OV_PRE];
    warn_cond[gas_pkg::W_VLT_UN] = safety_on_reg && (meas.volt < thr_reg[gas_pkg::T_VLT_UN_PRE]);
    warn_cond[gas_pkg::W_ECU] = ctrl_reg[gas_pkg::CTRL_CAN_EN] && engine.ecu_error;
    warn_cond[gas_pkg::W_CURRENT] = over_trip[0];
  end

  always_comb begin
    shut_cond = '0;
    // earth fault after time over trip
    shut_cond[gas_pkg::S_EARTH] = acc_done[1];
    shut_cond[gas_pkg::S_FAIL_START] = (attempts_lim_reg != 4'h0) &&
                                       (attempts_reg >= attempts_lim_reg);
    shut_cond[gas_pkg::S_ESTOP] = !estop_present;
    shut_cond[gas_pkg::S_OIL] = safety_on_reg && (meas.oil < thr_reg[gas_pkg::T_OIL_TRIP]);
    shut_cond[gas_pkg::S_TEMP_HI] = safety_on_reg &&
                                    (meas.coolant > thr_reg[gas_pkg::T_TEMP_TRIP]);
    shut_cond[gas_pkg::S_ROTATION] = engine.running &&
                                     (engine.rot_fwd != ctrl_reg[gas_pkg::CTRL_ROT_DIR]);
    shut_cond[gas_pkg::S_SPD_OV] = meas.speed > spd_trip;
    // underspeed delayed, frequency and voltage always
    shut_cond[gas_pkg::S_SPD_UN] = safety_on_reg && (meas.speed < thr_reg[gas_pkg::T_SPD_UN_TRIP]);
    shut_cond[gas_pkg::S_FRQ_OV] = meas.freq > thr_reg[gas_pkg::T_FRQ_OV_TRIP];
    shut_cond[gas_pkg::S_FRQ_UN] = meas.freq < thr_reg[gas_pkg::T_FRQ_UN_TRIP];
    shut_cond[gas_pkg::S_VLT_OV] = meas.volt > thr_reg[gas_pkg::T_VLT_OV_TRIP];
    shut_cond[gas_pkg::S_VLT_UN] = meas.volt < thr_reg[gas_pkg::T_VLT_UN_TRIP];
    shut_cond[gas_pkg::S_CURRENT] = acc_done[0];
  end

  // ************************************************************
  // latching and reset
  // ************************************************************
  // refuse reset on a live non-delayed condition
  assign blocking = |(shut_cond & ~gas_pkg::S_DELAYED);
  assign reset_accept = stop_reset_btn && ack_reg && !blocking;

  // self-clear unless latch-all; a live condition always wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      warn_reg <= '0;
    end else begin
      warn_reg <= warn_cond | (warn_reg & {gas_pkg::W_N{ctrl_reg[gas_pkg::CTRL_LATCH_ALL] &&
                                                      !stop_reset_btn}});
    end
  end

  // shutdowns latch until an accepted reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shut_reg <= '0;
    end else begin
      shut_reg <= shut_cond | (shut_reg & {gas_pkg::S_N{!reset_accept}});
    end
  end

  assign warn = warn_reg;
  assign shutdown = shut_reg;
  assign stop_engine = |shut_reg;
  // stop input cuts fuel and starter without waiting for a clock
  assign fuel_en = fuel_req && estop_present && !stop_engine;
  assign starter_en = starter_req && estop_present && !stop_engine;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_estop_cuts_out: assert property (!estop_present |-> !fuel_en && !starter_en)
    else $error("fuel or starter on without stop input");
  a_estop_latches: assert property (!estop_present |=> shutdown[gas_pkg::S_ESTOP] && stop_engine)
    else $error("stop input loss not latched");
  a_warn_self_clear: assert property (
    !ctrl_reg[gas_pkg::CTRL_LATCH_ALL] && meas.speed <= thr_reg[gas_pkg::T_SPD_OV_PRE]
    |=> !warn[gas_pkg::W_SPD_OV])
    else $error("overspeed warning did not clear");
  a_warn_latch_hold: assert property (
    ctrl_reg[gas_pkg::CTRL_LATCH_ALL] && warn[gas_pkg::W_TEMP_LO] && !stop_reset_btn
    |=> warn[gas_pkg::W_TEMP_LO])
    else $error("latched warning dropped");
  a_oil_warn_gated: assert property (
    !engine.running ##1 !engine.running && !ctrl_reg[gas_pkg::CTRL_LATCH_ALL]
    ##1 !engine.running && !ctrl_reg[gas_pkg::CTRL_LATCH_ALL]
    |-> !warn[gas_pkg::W_OIL])
    else $error("oil warning at rest");
  a_delay_start: assert property (
    $rose(engine.running) && safety_ms_reg != 16'h0000 |=> !safety_on_reg [*2])
    else $error("post-start delay skipped");
  a_shut_hold: assert property (stop_engine && !reset_accept |=> stop_engine)
    else $error("shutdown dropped without reset");
  a_reset_refused: assert property (
    stop_reset_btn && blocking && stop_engine |=> stop_engine && shut_reg != '0)
    else $error("reset taken while fault present");
  a_hc_escalate: assert property (acc_done[0] |=> shutdown[gas_pkg::S_CURRENT])
    else $error("overcurrent not escalated");
  a_overshoot_margin: assert property (
    !engine.starting && meas.speed > thr_reg[gas_pkg::T_SPD_OV_TRIP]
    |=> shutdown[gas_pkg::S_SPD_OV])
    else $error("overspeed trip missed");

  c_reset_done: cover property (stop_engine ##1 reset_accept ##1 !stop_engine);
  c_oil_warn: cover property ($rose(safety_on_reg) ##[1:20] warn[gas_pkg::W_OIL]);
  c_hc_trip: cover property (warn[gas_pkg::W_CURRENT] ##[1:50] shutdown[gas_pkg::S_CURRENT]);

endmodule // gas_supervisor

`default_nettype wire

// File: verification/gas_plant_model.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// engine, sensor and control unit model
// ************************************************************
module gas_plant_model (
  // clock
  input wire logic clk_sys,
  // bench commands
  input wire gas_pkg::gas_meas_s meas_set,
  input wire logic run_set,
  input wire logic ecu_err_set,
  // toward the supervisor
  output var gas_pkg::gas_meas_s meas,
  output var gas_pkg::gas_engine_s engine
);
  // sensors sample once a cycle, so every change reaches the supervisor one edge late
  always_ff @(posedge clk_sys) begin
    meas <= meas_set;
    engine <= {run_set, 1'b0, run_set, 1'b0, 1'b0, ecu_err_set};
  end
endmodule // gas_plant_model
`default_nettype wire

// File: verification/generator_alarm_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module generator_alarm_supervisor_bench;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  gas_pkg::gas_meas_s meas_set = '0;
  gas_pkg::gas_meas_s meas;
  gas_pkg::gas_engine_s engine;
  logic run_set = 1'b0;
  logic ecu_err_set = 1'b0;
  logic estop_present = 1'b1;
  logic stop_reset_btn = 1'b0;
  logic fuel_req = 1'b1;
  logic starter_req = 1'b1;
  logic [gas_pkg::W_N-1:0] warn;
  logic [gas_pkg::S_N-1:0] shutdown;
  logic stop_engine;
  logic fuel_en;
  logic starter_en;
  int err_count = 0;
  int n_checks = 0;
  int seed = 70;
  int i;

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  gas_plant_model model (.clk_sys(clk_sys), .meas_set(meas_set), .run_set(run_set),
    .ecu_err_set(ecu_err_set), .meas(meas), .engine(engine));

  // short tick keeps the post-start delay to a few tens of cycles
  gas_supervisor #(.TICK_CYCLES(10)) DUT (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas(meas), .engine(engine), .estop_present(estop_present),
    .stop_reset_btn(stop_reset_btn), .fuel_req(fuel_req), .starter_req(starter_req),
    .warn(warn), .shutdown(shutdown), .stop_engine(stop_engine), .fuel_en(fuel_en),
    .starter_en(starter_en));

  // ************************************************************
  // tasks and expectations
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic thr(input int idx, input logic [15:0] v);
    wr(gas_pkg::ADDR_THR_BASE + 8'(4 * idx), {16'h0000, v});
  endtask

  // model edge plus supervisor edge before the alarm bits show
  task automatic set_meas(input gas_pkg::gas_meas_s m);
    @(posedge clk_sys);
    meas_set <= m;
    tick(2);
  endtask

  task automatic press;
    @(posedge clk_sys);
    stop_reset_btn <= 1'b1;
    @(posedge clk_sys);
    stop_reset_btn <= 1'b0;
    tick(1);
  endtask

  // bit 0 overspeed warning, bit 1 underspeed warning
  function automatic logic [1:0] exp_spd(input logic [15:0] s);
    return {s < 16'h1000, s > 16'h8000};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    gas_pkg::gas_meas_s m;
    logic [15:0] corner [4];
    corner = '{16'h8000, 16'h8001, 16'h1000, 16'h0FFF};
    m = '0;
    m.speed = 16'h4000;
    m.oil = 16'h4000;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("warn reg", gas_pkg::ADDR_WARN, 32'h0);
    rd_chk("shut reg", gas_pkg::ADDR_SHUT, 32'h0);
    rd_chk("ctrl reg", gas_pkg::ADDR_CTRL, 32'h0);
    rd_chk("over limit", gas_pkg::ADDR_THR_BASE + 8'h1C, 32'h0000FFFF);
    rd_chk("unmapped", 8'h3C, 32'h0);
    thr(gas_pkg::T_SPD_OV_PRE, 16'h8000);
    thr(gas_pkg::T_SPD_UN_PRE, 16'h1000);
    thr(gas_pkg::T_SPD_OV_TRIP, 16'hC000);
    thr(gas_pkg::T_OIL_PRE, 16'h0100);
    thr(gas_pkg::T_OIL_TRIP, 16'h0080);
    set_meas(m);
    $display("test reset_values done");
    for (i = 0; i < 44; i++) begin
      m.speed = (i < 4) ? corner[i] : 16'($random(seed)) & 16'hBFFF;
      set_meas(m);
      chk("speed warn", {30'h0, exp_spd(m.speed)}, {30'h0, warn[4], warn[3]});
    end
    $display("test speed_warnings done");
    wr(gas_pkg::ADDR_CTRL, 32'h1);
    m.speed = 16'h9000;
    set_meas(m);
    m.speed = 16'h4000;
    set_meas(m);
    chk("latched warn", 32'h1, warn[gas_pkg::W_SPD_OV]);
    press;
    chk("warn after reset", 32'h0, warn[gas_pkg::W_SPD_OV]);
    wr(gas_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    ecu_err_set <= 1'b1;
    tick(2);
    chk("ecu can off", 32'h0, warn[gas_pkg::W_ECU]);
    wr(gas_pkg::ADDR_CTRL, 32'h2);
    tick(2);
    chk("ecu can on", 32'h1, warn[gas_pkg::W_ECU]);
    @(posedge clk_sys);
    ecu_err_set <= 1'b0;
    tick(2);
    chk("ecu cleared", 32'h0, warn[gas_pkg::W_ECU]);
    $display("test latch_and_ecu done");
    m.speed = 16'hC001;
    set_meas(m);
    chk("overspeed shut", 32'h1, shutdown[gas_pkg::S_SPD_OV]);
    chk("overspeed warn", 32'h1, warn[gas_pkg::W_SPD_OV]);
    chk("stop", 32'h1, stop_engine);
    chk("fuel", 32'h0, fuel_en);
    wr(gas_pkg::ADDR_ACK, 32'h1);
    press;
    chk("reset refused", 32'h1, shutdown[gas_pkg::S_SPD_OV]);
    m.speed = 16'h4000;
    set_meas(m);
    press;
    chk("reset taken", 32'h0, shutdown[gas_pkg::S_SPD_OV]);
    m.speed = 16'hD000;
    set_meas(m);
    m.speed = 16'h4000;
    set_meas(m);
    press;
    chk("no ack", 32'h1, shutdown[gas_pkg::S_SPD_OV]);
    $display("test overspeed_shutdown done");
    @(posedge clk_sys);
    estop_present <= 1'b0;
    #1;
    chk("fuel cut", 32'h0, {fuel_en, starter_en});
    tick(1);
    chk("estop shut", 32'h1, shutdown[gas_pkg::S_ESTOP]);
    @(posedge clk_sys);
    estop_present <= 1'b1;
    wr(gas_pkg::ADDR_ACK, 32'h1);
    press;
    chk("all clear", 32'h0, {stop_engine, shutdown});
    $display("test emergency_stop done");
    wr(gas_pkg::ADDR_SAFETY, 32'h3);
    m.oil = 16'h0050;
    set_meas(m);
    tick(40);
    chk("oil at rest", 32'h0, {warn[gas_pkg::W_OIL], shutdown[gas_pkg::S_OIL]});
    @(posedge clk_sys);
    run_set <= 1'b1;
    for (i = 0; i < 80 && warn[gas_pkg::W_OIL] !== 1'b1; i++)
      tick(1);
    chk("delay cycles", 32'h1, {31'h0, i >= 28 && i < 40});
    chk("oil shut", 32'h1, shutdown[gas_pkg::S_OIL]);
    @(posedge clk_sys);
    run_set <= 1'b0;
    wr(gas_pkg::ADDR_ACK, 32'h1);
    press;
    chk("delayed reset", 32'h0, shutdown[gas_pkg::S_OIL]);
    $display("test post_start_delay done");
    tally_and_finish;
  end
endmodule // generator_alarm_supervisor_bench
`default_nettype wire
